// ===== rtl/fcs_pkg.sv
// Overview of operation
// - Command cycle: output enable high, chip and write enable low; latched on first rise.
// - Host programs with output enable high, strobes low, supply high, unlock for boot; the controller starts a program whatever CTRL holds.
// - Program address and data latch on first rising strobe, only right after write setup.
// - Host never issues 00H or any undefined command code.
// - Host holds program supply and boot unlock until the ready bit reads one; the controller leaves both to software and polls at most POLL_LIMIT times.
`default_nettype none
package fcs_pkg;
  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] FCS_CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] FCS_CMD_IDENTIFY = 8'h90;
  localparam logic [7:0] FCS_CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] FCS_CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] FCS_CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] FCS_CMD_CONFIRM = 8'hD0;
  localparam logic [7:0] FCS_CMD_WRITE_SETUP = 8'h40;
  localparam logic [7:0] FCS_CMD_WRITE_SETUP_ALT = 8'h10;
  localparam logic [7:0] FCS_CMD_SUSPEND = 8'hB0;
  // ----------------------------------------------------------------
  // Status bit positions
  // ----------------------------------------------------------------
  localparam int FCS_SR_READY = 7;
  localparam int FCS_SR_SUSPEND = 6;
  localparam int FCS_SR_ERASE_FAIL = 5;
  localparam int FCS_SR_PROG_FAIL = 4;
  localparam int FCS_SR_SUPPLY_MISSING = 3;
  // ----------------------------------------------------------------
  // Controller register map (word index on the software port)
  // ----------------------------------------------------------------
  localparam logic [3:0] FCS_REG_CTRL = 4'h0;
  localparam logic [3:0] FCS_REG_ADDR = 4'h1;
  localparam logic [3:0] FCS_REG_DATA = 4'h2;
  localparam logic [3:0] FCS_REG_OP = 4'h3;
  localparam logic [3:0] FCS_REG_RESULT = 4'h4;
  localparam logic [3:0] FCS_REG_STATE = 4'h5;
  localparam logic [31:0] FCS_CTRL_RESET = 32'h0000_0000;
  // Op codes written to FCS_REG_OP.
  localparam logic [2:0] FCS_OP_WRITE_CMD = 3'h0;
  localparam logic [2:0] FCS_OP_READ = 3'h1;
  localparam logic [2:0] FCS_OP_PROGRAM = 3'h2;
  localparam logic [2:0] FCS_OP_ERASE = 3'h3;
  localparam logic [2:0] FCS_OP_POLL = 3'h4;
  // CTRL field positions.
  localparam int FCS_CTRL_SUPPLY = 0;
  localparam int FCS_CTRL_UNLOCK = 1;
  localparam int FCS_CTRL_ID_VOLT = 2;
  localparam int FCS_CTRL_DEV_RESET = 3;
  // ----------------------------------------------------------------
  // Bus timing
  // ----------------------------------------------------------------
  localparam int FCS_CLK_NS = 10;
  localparam int FCS_STROBE_NS = 50;
  localparam int FCS_STROBE_CYC = (FCS_STROBE_NS + FCS_CLK_NS - 1) / FCS_CLK_NS;
  localparam int FCS_RECOVER_NS = 30;
  localparam int FCS_RECOVER_CYC = (FCS_RECOVER_NS + FCS_CLK_NS - 1) / FCS_CLK_NS;
  localparam int FCS_POLL_LIMIT = 100000;

  typedef enum logic [2:0]
  {
    FCS_ST_IDLE = 3'b000,
    FCS_ST_ASSERT = 3'b001,
    FCS_ST_RELEASE = 3'b010,
    FCS_ST_NEXT = 3'b011,
    FCS_ST_DONE = 3'b100
  } fcs_state_e;
endpackage
`default_nettype wire

// ===== rtl/fcs_bus_cycle.sv
`default_nettype none
// One strobe cycle on the flash pins: write or read.
module fcs_bus_cycle
  import fcs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Request
  input wire logic start,
  input wire logic is_write,
  input wire logic [18:0] addr_in,
  input wire logic [7:0] wdata_in,
  output logic busy,
  output logic done,
  output logic [7:0] rdata,
  // Flash pins
  output logic [18:0] address_lines,
  output logic chip_enable_n,
  output logic output_enable_n,
  output logic write_enable_n,
  output logic [7:0] data_lines_out,
  output logic data_lines_oe,
  input wire logic [7:0] data_lines_in
);
  import fcs_pkg::*;
  localparam int CW = 4;
  localparam logic [CW-1:0] STROBE_LAST = CW'(FCS_STROBE_CYC - 1);
  localparam logic [CW-1:0] RECOVER_LAST = CW'(FCS_RECOVER_CYC - 1);
  typedef enum logic [1:0]
  {
    FCS_BC_IDLE = 2'b00,
    FCS_BC_LOW = 2'b01,
    FCS_BC_HIGH = 2'b10
  } fcs_bc_e;
  fcs_bc_e state_reg;
  logic [CW-1:0] cnt_reg;
  logic wr_reg;

  assign busy = (state_reg != FCS_BC_IDLE);

  // ----------------------------------------------------------------
  // Strobe sequencing
  // ----------------------------------------------------------------
  // Chip enable and write enable rise together, so the data latches
  // on a single well defined edge whichever one the device sees first.
  always_ff @(posedge clk)
  begin
    done <= 1'b0;
    if (!reset_n)
    begin
      state_reg <= FCS_BC_IDLE;
      cnt_reg <= '0;
      wr_reg <= 1'b0;
      chip_enable_n <= 1'b1;
      output_enable_n <= 1'b1;
      write_enable_n <= 1'b1;
      data_lines_oe <= 1'b1;
      data_lines_out <= 8'h00;
      address_lines <= 19'h00000;
      rdata <= 8'h00;
    end
    else
    begin
      unique case (state_reg)
        FCS_BC_IDLE:
        begin
          if (start)
          begin
            state_reg <= FCS_BC_LOW;
            cnt_reg <= '0;
            wr_reg <= is_write;
            address_lines <= addr_in;
            data_lines_out <= wdata_in;
            chip_enable_n <= 1'b0;
            output_enable_n <= is_write;
            write_enable_n <= !is_write;
            data_lines_oe <= !is_write;
          end
        end
        FCS_BC_LOW:
        begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == STROBE_LAST)
          begin
            if (!wr_reg)
              rdata <= data_lines_in;
            chip_enable_n <= 1'b1;
            write_enable_n <= 1'b1;
            output_enable_n <= 1'b1;
            cnt_reg <= '0;
            state_reg <= FCS_BC_HIGH;
          end
        end
        FCS_BC_HIGH:
        begin
          data_lines_oe <= 1'b1;
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == RECOVER_LAST)
          begin
            state_reg <= FCS_BC_IDLE;
            done <= 1'b1;
          end
        end
        default:
          state_reg <= FCS_BC_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_cmd_oe_high: assert property (@(posedge clk) disable iff (!reset_n)
    !write_enable_n |-> output_enable_n && !chip_enable_n)
    else $error("write strobe without output enable high");
  a_strobe_width: assert property (@(posedge clk) disable iff (!reset_n)
    $fell(write_enable_n) |-> !write_enable_n [*5] ##1 write_enable_n)
    else $error("write strobe width wrong");
  c_write_cycle: cover property (@(posedge clk) disable iff (!reset_n) $fell(write_enable_n));
  c_read_cycle: cover property (@(posedge clk) disable iff (!reset_n) $fell(output_enable_n));
endmodule
`default_nettype wire

// ===== rtl/fcs_controller.sv
// Implementation choices: the address-and-strobe port and the register addresses.
`default_nettype none
// Host-side controller that sequences commands into the flash device.
module fcs_controller
  import fcs_pkg::*;
#(
  parameter int POLL_LIMIT = fcs_pkg::FCS_POLL_LIMIT
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Software port
  input wire logic [3:0] sw_addr,
  input wire logic [31:0] sw_wdata,
  input wire logic sw_write,
  input wire logic sw_read,
  output logic [31:0] sw_rdata,
  // Flash strobes and address
  output logic [18:0] address_lines,
  output logic chip_enable_n,
  output logic output_enable_n,
  output logic write_enable_n,
  // Flash data lines
  output logic [7:0] data_lines_out,
  output logic data_lines_oe,
  input wire logic [7:0] data_lines_in,
  // Voltage qualifiers
  output logic program_supply_high,
  output logic boot_unlock_high,
  output logic id_detect_high,
  output logic device_reset_n
);
  import fcs_pkg::*;

  fcs_state_e state_reg;
  logic [31:0] ctrl_reg;
  logic [18:0] addr_reg;
  logic [7:0] data_reg;
  logic [2:0] op_reg;
  logic [7:0] result_reg;
  logic [7:0] status_reg;
  logic busy_err_reg;
  logic timeout_reg;
  logic phase_reg;
  logic [16:0] poll_cnt_reg;
  logic bc_start;
  logic bc_write;
  logic [7:0] bc_wdata;
  logic bc_busy;
  logic bc_done;
  logic [7:0] bc_rdata;
  logic last_phase;
  logic polling;

  // Decodes whether a code belongs to the defined command set.
  function automatic logic fcs_valid_cmd(input logic [7:0] c);
    fcs_valid_cmd = (c == FCS_CMD_READ_ARRAY) || (c == FCS_CMD_IDENTIFY) ||
                    (c == FCS_CMD_READ_STATUS) || (c == FCS_CMD_CLEAR_STATUS) ||
                    (c == FCS_CMD_ERASE_SETUP) || (c == FCS_CMD_CONFIRM) ||
                    (c == FCS_CMD_WRITE_SETUP) || (c == FCS_CMD_WRITE_SETUP_ALT) ||
                    (c == FCS_CMD_SUSPEND);
  endfunction

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  wire sw_op_go = sw_write && (sw_addr == FCS_REG_OP);
  // Undefined codes are refused here so they never reach the device.
  wire op_legal = (sw_wdata[2:0] != FCS_OP_WRITE_CMD) || fcs_valid_cmd(data_reg);
  wire op_accept = sw_op_go && (state_reg == FCS_ST_IDLE) && op_legal &&
                   (sw_wdata[2:0] <= FCS_OP_POLL);

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      ctrl_reg <= FCS_CTRL_RESET;
      addr_reg <= 19'h00000;
      data_reg <= 8'h00;
      op_reg <= FCS_OP_WRITE_CMD;
    end
    else if (sw_write)
    begin
      if (sw_addr == FCS_REG_CTRL)
        ctrl_reg <= {28'h0000000, sw_wdata[3:0]};
      if (sw_addr == FCS_REG_ADDR)
        addr_reg <= sw_wdata[18:0];
      if (sw_addr == FCS_REG_DATA)
        data_reg <= sw_wdata[7:0];
      if (op_accept)
        op_reg <= sw_wdata[2:0];
    end
  end

  // Supply and unlock drives stay as software set them, and the poll
  // loop ends only on ready or after POLL_LIMIT polls; CTRL writes are taken in any state, so holding them until ready is left to software.
  assign program_supply_high = ctrl_reg[FCS_CTRL_SUPPLY];
  assign boot_unlock_high = ctrl_reg[FCS_CTRL_UNLOCK];
  assign id_detect_high = ctrl_reg[FCS_CTRL_ID_VOLT];
  assign device_reset_n = !ctrl_reg[FCS_CTRL_DEV_RESET];

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      sw_rdata <= 32'h0000_0000;
    else if (sw_read)
    begin
      unique case (sw_addr)
        FCS_REG_CTRL: sw_rdata <= ctrl_reg;
        FCS_REG_ADDR: sw_rdata <= {13'h0000, addr_reg};
        FCS_REG_DATA: sw_rdata <= {24'h000000, data_reg};
        FCS_REG_OP: sw_rdata <= {29'h00000000, op_reg};
        FCS_REG_RESULT: sw_rdata <= {16'h0000, status_reg, result_reg};
        FCS_REG_STATE: sw_rdata <= {28'h0000000, timeout_reg, busy_err_reg,
                                    1'b0, state_reg != FCS_ST_IDLE};
        default: sw_rdata <= 32'h0000_0000;
      endcase
    end
    else
      sw_rdata <= 32'h0000_0000;
  end

  // ----------------------------------------------------------------
  // Operation sequencer
  // ----------------------------------------------------------------
  // Program and erase are two cycles; the first carries the setup code.
  assign last_phase = ((op_reg != FCS_OP_PROGRAM) && (op_reg != FCS_OP_ERASE)) || phase_reg;
  assign polling = (op_reg == FCS_OP_POLL) || (op_reg == FCS_OP_PROGRAM) ||
                   (op_reg == FCS_OP_ERASE);
  // The done pulse arrives with busy already low, so it must also hold off
  // a restart or the same strobe cycle would run twice.
  assign bc_start = (state_reg == FCS_ST_ASSERT) && !bc_busy && !bc_done;

  always_comb
  begin
    bc_write = 1'b1;
    bc_wdata = data_reg;
    if (state_reg == FCS_ST_RELEASE || op_reg == FCS_OP_READ || op_reg == FCS_OP_POLL)
      bc_write = 1'b0;
    else if (op_reg == FCS_OP_PROGRAM && !phase_reg)
      bc_wdata = FCS_CMD_WRITE_SETUP;
    else if (op_reg == FCS_OP_ERASE && !phase_reg)
      bc_wdata = FCS_CMD_ERASE_SETUP;
    else if (op_reg == FCS_OP_ERASE)
      bc_wdata = FCS_CMD_CONFIRM;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      state_reg <= FCS_ST_IDLE;
      phase_reg <= 1'b0;
      poll_cnt_reg <= '0;
      result_reg <= 8'h00;
      status_reg <= 8'h00;
      busy_err_reg <= 1'b0;
      timeout_reg <= 1'b0;
    end
    else
    begin
      unique case (state_reg)
        FCS_ST_IDLE:
        begin
          if (sw_op_go && !op_accept)
            busy_err_reg <= 1'b1;
          else if (op_accept)
          begin
            busy_err_reg <= 1'b0;
            timeout_reg <= 1'b0;
            phase_reg <= 1'b0;
            poll_cnt_reg <= '0;
            state_reg <= FCS_ST_ASSERT;
          end
        end
        FCS_ST_ASSERT:
          if (bc_done)
            state_reg <= FCS_ST_NEXT;
        FCS_ST_NEXT:
        begin
          if (!last_phase)
          begin
            // Data cycle must follow setup with nothing in between.
            phase_reg <= 1'b1;
            state_reg <= FCS_ST_ASSERT;
          end
          else if (op_reg == FCS_OP_READ)
          begin
            result_reg <= bc_rdata;
            state_reg <= FCS_ST_DONE;
          end
          else if (op_reg == FCS_OP_WRITE_CMD)
            state_reg <= FCS_ST_DONE;
          else
            state_reg <= FCS_ST_RELEASE;
        end
        FCS_ST_RELEASE:
        begin
          // Each poll is a fresh strobe, since status only refreshes then.
          if (bc_done)
          begin
            status_reg <= bc_rdata;
            poll_cnt_reg <= poll_cnt_reg + 1'b1;
            if (bc_rdata[FCS_SR_READY])
              state_reg <= FCS_ST_DONE;
            else if (poll_cnt_reg == 17'(POLL_LIMIT - 1))
            begin
              timeout_reg <= 1'b1;
              state_reg <= FCS_ST_DONE;
            end
          end
        end
        FCS_ST_DONE:
          state_reg <= FCS_ST_IDLE;
        default:
          state_reg <= FCS_ST_IDLE;
      endcase
    end
  end

  wire bc_go = bc_start || ((state_reg == FCS_ST_RELEASE) && !bc_busy && !bc_done);

  fcs_bus_cycle u_cycle (
    .clk(clk),
    .reset_n(reset_n),
    .start(bc_go),
    .is_write(bc_write),
    .addr_in(addr_reg),
    .wdata_in(bc_wdata),
    .busy(bc_busy),
    .done(bc_done),
    .rdata(bc_rdata),
    .address_lines(address_lines),
    .chip_enable_n(chip_enable_n),
    .output_enable_n(output_enable_n),
    .write_enable_n(write_enable_n),
    .data_lines_out(data_lines_out),
    .data_lines_oe(data_lines_oe),
    .data_lines_in(data_lines_in)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_no_bad_code: assert property (@(posedge clk) disable iff (!reset_n)
    $fell(write_enable_n) && data_lines_oe == 1'b0 && !phase_reg && op_reg != FCS_OP_PROGRAM
    |-> fcs_valid_cmd(data_lines_out))
    else $error("undefined command code driven");
  a_supply_held: assert property (@(posedge clk) disable iff (!reset_n)
    (state_reg == FCS_ST_RELEASE) |-> $stable(program_supply_high))
    else $error("supply dropped while waiting for ready");
  a_setup_first: assert property (@(posedge clk) disable iff (!reset_n)
    (state_reg == FCS_ST_NEXT) && !last_phase |=> (state_reg == FCS_ST_ASSERT) && phase_reg)
    else $error("data cycle did not follow setup");
  a_ready_ends: assert property (@(posedge clk) disable iff (!reset_n)
    (state_reg == FCS_ST_RELEASE) && bc_done && bc_rdata[FCS_SR_READY] |=> state_reg == FCS_ST_DONE)
    else $error("poll did not stop on ready");
  a_program_oe: assert property (@(posedge clk) disable iff (!reset_n)
    !write_enable_n |-> output_enable_n)
    else $error("program cycle with output enable low");
  c_program: cover property (@(posedge clk) disable iff (!reset_n)
    op_accept && sw_wdata[2:0] == FCS_OP_PROGRAM);
  c_erase_done: cover property (@(posedge clk) disable iff (!reset_n)
    state_reg == FCS_ST_DONE && op_reg == FCS_OP_ERASE);
  c_timeout: cover property (@(posedge clk) disable iff (!reset_n) $rose(timeout_reg));
endmodule
`default_nettype wire

// ===== test/fcs_flash_model.sv
`default_nettype none
// Behavioural flash device seen through its strobes; the clock times the engine and samples the reset pin.
module fcs_flash_model
  import fcs_pkg::*;
#(
  parameter logic [7:0] MFR_ID = 8'h3C, // Arbitrary value.
  parameter logic [7:0] DEV_ID = 8'hA7 // Arbitrary value.
)
(
  // Engine timing
  input wire logic clk,
  input wire logic slow,
  // Pins
  input wire logic [18:0] address_lines,
  input wire logic chip_enable_n,
  input wire logic output_enable_n,
  input wire logic write_enable_n,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  // Qualifiers
  input wire logic program_supply_high,
  input wire logic boot_unlock_high,
  input wire logic id_detect_high,
  input wire logic device_reset_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  logic [7:0] sr = 8'h80;
  logic [7:0] q = 8'hFF;
  logic [1:0] mode = 2'd0;
  logic pend_w = 1'b0;
  logic pend_e = 1'b0;
  int busy = 0;
  wire logic wstb = chip_enable_n | write_enable_n;
  wire logic rstb = chip_enable_n | output_enable_n;
  initial foreach (mem[i]) mem[i] = 8'hFF;

  task automatic start(input logic prog);
    sr[3] = !program_supply_high;
    if (address_lines[18:14] == 5'h00 && !boot_unlock_high)
      sr[prog ? 4 : 5] = 1'b1;
    else if (program_supply_high)
    begin
      if (prog)
        mem[address_lines[7:0]] &= data_in;
      else
        foreach (mem[i]) mem[i] = 8'hFF;
      sr[7] = 1'b0;
      busy = slow ? 400 : 30;
    end
  endtask

  // Commands are ignored while the engine runs, so a poll can never start a second job.
  always @(posedge wstb)
  begin
    if (device_reset_n && output_enable_n && busy == 0)
    begin
      if (pend_w)
      begin
        pend_w = 1'b0;
        mode = 2'd2;
        if (data_in != FCS_CMD_READ_ARRAY && !sr[3])
          start(1'b1);
      end
      else if (pend_e)
      begin
        pend_e = 1'b0;
        mode = (data_in == FCS_CMD_CONFIRM) ? 2'd2 : 2'd0;
        if (data_in != FCS_CMD_CONFIRM)
          sr[5] = 1'b1;
        else if (!sr[3])
          start(1'b0);
      end
      else
        case (data_in)
          FCS_CMD_READ_ARRAY: mode = 2'd0;
          FCS_CMD_IDENTIFY: mode = 2'd1;
          FCS_CMD_READ_STATUS: mode = 2'd2;
          FCS_CMD_CLEAR_STATUS: sr[5:3] = 3'h0;
          FCS_CMD_WRITE_SETUP, FCS_CMD_WRITE_SETUP_ALT: pend_w = 1'b1;
          FCS_CMD_ERASE_SETUP: pend_e = 1'b1;
          default: ;
        endcase
    end
  end

  always @(posedge clk)
  begin
    if (!device_reset_n)
    begin
      sr = 8'h80;
      mode = 2'd0;
      pend_w = 1'b0;
      pend_e = 1'b0;
      busy = 0;
    end
    else if (busy != 0)
    begin
      busy = busy - 1;
      if (busy == 0)
        sr[7] = 1'b1;
    end
  end

  // Output is latched at the strobe fall and does not follow later status changes.
  always @(negedge rstb)
  begin
    if (id_detect_high || mode == 2'd1)
      q = address_lines[0] ? DEV_ID : MFR_ID;
    else if (mode == 2'd2 || busy != 0)
      q = sr;
    else
      q = mem[address_lines[7:0]];
  end
  // A released bus shows the inverse of the last byte, never a stale copy.
  assign data_out = rstb ? ~q : q;
endmodule
`default_nettype wire

// ===== test/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import fcs_pkg::*;
  localparam logic [7:0] MFR = 8'h3C; // Arbitrary value.
  localparam logic [7:0] DEV = 8'hA7; // Arbitrary value.
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] sw_addr = 4'h0;
  logic [31:0] sw_wdata = 32'h0;
  logic sw_write = 1'b0;
  logic sw_read = 1'b0;
  logic slow = 1'b0;
  logic [31:0] sw_rdata, v, res;
  logic [18:0] address_lines;
  logic chip_enable_n, output_enable_n, write_enable_n, data_lines_oe;
  logic [7:0] data_lines_out, dev_out;
  logic program_supply_high, boot_unlock_high, id_detect_high, device_reset_n;
  wire logic [7:0] bus = !data_lines_oe ? data_lines_out : dev_out;
  int err_count = 0;
  int num_checks = 0;
  int cycles = 0;

  always #5 clk = ~clk;

  fcs_controller #(.POLL_LIMIT(20)) dut_u (.clk, .reset_n, .sw_addr, .sw_wdata, .sw_write, .sw_read,
    .sw_rdata, .address_lines, .chip_enable_n, .output_enable_n, .write_enable_n, .data_lines_out,
    .data_lines_oe, .data_lines_in(bus), .program_supply_high, .boot_unlock_high, .id_detect_high,
    .device_reset_n);
  fcs_flash_model #(.MFR_ID(MFR), .DEV_ID(DEV)) dev_u (.clk, .slow, .address_lines, .chip_enable_n,
    .output_enable_n, .write_enable_n, .data_in(bus), .data_out(dev_out), .program_supply_high,
    .boot_unlock_high, .id_detect_high, .device_reset_n);

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    sw_addr <= a;
    sw_wdata <= d;
    sw_write <= 1'b1;
    @(posedge clk);
    sw_write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    sw_addr <= a;
    sw_read <= 1'b1;
    @(posedge clk);
    sw_read <= 1'b0;
    #1;
    d = sw_rdata;
    @(posedge clk);
  endtask

  // Busy is bounded so a stuck sequencer shows up as a failed check, not a hang.
  task automatic run(input logic [2:0] op);
    int n;
    n = 0;
    wr(FCS_REG_OP, {29'h0, op});
    v = 32'h1;
    while (v[0] === 1'b1 && n < 400)
    begin
      rd(FCS_REG_STATE, v);
      n++;
    end
    chk("op finished", 32'h0, {31'h0, v[0]});
    rd(FCS_REG_RESULT, res);
  endtask

  task automatic cmd(input logic [7:0] c);
    wr(FCS_REG_DATA, {24'h0, c});
    run(FCS_OP_WRITE_CMD);
  endtask

  task automatic prog(input logic [18:0] a, input logic [7:0] d, input logic [7:0] e);
    wr(FCS_REG_ADDR, {13'h0, a});
    wr(FCS_REG_DATA, {24'h0, d});
    run(FCS_OP_PROGRAM);
    chk("program status", {24'h0, e}, {24'h0, res[15:8]});
  endtask

  task automatic rdb(input logic [18:0] a, input logic [7:0] e, input string what);
    wr(FCS_REG_ADDR, {13'h0, a});
    run(FCS_OP_READ);
    chk(what, {24'h0, e}, {24'h0, res[7:0]});
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      err_count++;
      conclude();
    end
  end

  initial
  begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd(FCS_REG_STATE, v);
    chk("state after reset", 32'h0, v);
    chk("idle pins", 32'hF, {28'h0, chip_enable_n, output_enable_n, write_enable_n, data_lines_oe});
    wr(FCS_REG_CTRL, 32'h3);
    rd(FCS_REG_CTRL, v);
    chk("ctrl", 32'h3, v);
    chk("qualifiers", 32'hB, {28'h0, device_reset_n, id_detect_high, boot_unlock_high, program_supply_high});
    rdb(19'h5, 8'hFF, "erased byte");
    prog(19'h5, 8'hA5, 8'h80);
    rdb(19'h5, 8'h80, "status mode after program");
    cmd(FCS_CMD_READ_ARRAY);
    rdb(19'h5, 8'hA5, "programmed byte");
    prog(19'h5, 8'h5A, 8'h80);
    prog(19'h5, 8'hFF, 8'h80);
    cmd(FCS_CMD_READ_ARRAY);
    rdb(19'h5, 8'h00, "bits only cleared");
    wr(FCS_REG_ADDR, 32'h6);
    cmd(FCS_CMD_WRITE_SETUP_ALT);
    cmd(8'h50);
    repeat (40) @(posedge clk);
    cmd(FCS_CMD_READ_ARRAY);
    rdb(19'h6, 8'h50, "alternate setup");
    cmd(FCS_CMD_IDENTIFY);
    rdb(19'h0, MFR, "maker id");
    rdb(19'h1, DEV, "device id");
    cmd(FCS_CMD_READ_STATUS);
    rdb(19'h0, 8'h80, "status read");
    wr(FCS_REG_CTRL, 32'h2);
    prog(19'h9, 8'h00, 8'h88);
    wr(FCS_REG_CTRL, 32'h3);
    prog(19'h9, 8'h00, 8'h88);
    cmd(FCS_CMD_READ_ARRAY);
    rdb(19'h9, 8'hFF, "start refused");
    cmd(FCS_CMD_CLEAR_STATUS);
    cmd(FCS_CMD_READ_STATUS);
    rdb(19'h0, 8'h80, "cleared status");
    wr(FCS_REG_CTRL, 32'h1);
    prog(19'h9, 8'h00, 8'h90);
    wr(FCS_REG_CTRL, 32'hB);
    @(posedge clk);
    chk("device reset pin", 32'h0, {31'h0, device_reset_n});
    wr(FCS_REG_CTRL, 32'h3);
    rdb(19'h5, 8'h00, "array after reset");
    cmd(FCS_CMD_READ_STATUS);
    rdb(19'h0, 8'h80, "errors cleared by reset");
    wr(FCS_REG_ADDR, 32'h5);
    run(FCS_OP_ERASE);
    chk("erase status", 32'h80, {24'h0, res[15:8]});
    cmd(FCS_CMD_READ_ARRAY);
    rdb(19'h5, 8'hFF, "erased block");
    cmd(FCS_CMD_ERASE_SETUP);
    cmd(FCS_CMD_READ_STATUS);
    rdb(19'h6, 8'hFF, "array after bad confirm");
    cmd(FCS_CMD_READ_STATUS);
    rdb(19'h0, 8'hA0, "sequence error");
    cmd(FCS_CMD_CLEAR_STATUS);
    wr(FCS_REG_CTRL, 32'h7);
    rdb(19'h1, DEV, "id by voltage");
    wr(FCS_REG_CTRL, 32'h3);
    rdb(19'h1, 8'h80, "previous mode back");
    slow <= 1'b1;
    prog(19'hA, 8'h0F, 8'h00);
    rd(FCS_REG_STATE, v);
    chk("poll timeout", 32'h1, {31'h0, v[3]});
    slow <= 1'b0;
    repeat (400) @(posedge clk);
    cmd(8'h00);
    rd(FCS_REG_STATE, v);
    chk("undefined code refused", 32'h1, {31'h0, v[2]});
    rd(4'hF, v);
    chk("unmapped read", 32'h0, v);
    conclude();
  end
endmodule
`default_nettype wire
